/* sim/dsr_bank_properties.sv */
// dsr_bank_properties: port-level checks of the debug status bank
// assumes: bound to the bank top module, single clock domain
`timescale 1ns/1ps
module dsr_bank_properties
  import dsr_pkg::*;
#(
  parameter int TAG_DELAY = DSR_TAG_DELAY
)(
  input wire logic     CLOCK,
  input wire logic     RST_N,
  input wire logic     ACC_VALID,
  input wire logic     ACC_WRITE,
  input wire logic     ACC_RVALID,
  input wire logic     ACC_REFUSED,
  input wire dsr_src_t ACC_SRC,
  input wire logic     ENTRY_REQ,
  input wire logic     TAG_GO_CMD,
  input wire logic     DEBUG_ENABLE,
  input wire logic     DEBUG_ACTIVE,
  input wire logic     FW_TABLE_MAPPED,
  input wire logic     SERIAL_ENABLE,
  input wire logic     TAG_FUNCTION_ON
);
  localparam int TD1 = TAG_DELAY + 1;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // access answers and refusals
  property p_rv; ACC_VALID && !ACC_WRITE && !ACC_REFUSED |=> ACC_RVALID; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_refnone; ACC_VALID && ACC_SRC == DSR_SRC_NONE |-> ACC_REFUSED; endproperty
  a_refnone: assert property (p_refnone) else $error("sourceless access taken");
  property p_reftag; ACC_VALID && TAG_FUNCTION_ON |-> ACC_REFUSED; endproperty
  a_reftag: assert property (p_reftag) else $error("access taken while tagging");
  // entry, activation and tag timing
  property p_ent; ENTRY_REQ && DEBUG_ENABLE && !DEBUG_ACTIVE |=> DEBUG_ACTIVE && !TAG_FUNCTION_ON;
  endproperty
  a_ent: assert property (p_ent) else $error("entry not taken");
  property p_noent; !DEBUG_ENABLE && !DEBUG_ACTIVE |=> !DEBUG_ACTIVE; endproperty
  a_noent: assert property (p_noent) else $error("active while disabled");
  property p_map; FW_TABLE_MAPPED == DEBUG_ACTIVE; endproperty
  a_map: assert property (p_map) else $error("table map differs from active");
  property p_tag; $rose(TAG_FUNCTION_ON) |-> $past(TAG_GO_CMD, TD1); endproperty
  a_tag: assert property (p_tag) else $error("tagging at wrong time");
  property p_set; $rose(DEBUG_ACTIVE) |-> $past(ENTRY_REQ); endproperty
  a_set: assert property (p_set) else $error("active set without entry");
  property p_ser; SERIAL_ENABLE != TAG_FUNCTION_ON; endproperty
  a_ser: assert property (p_ser) else $error("serial link and tagging overlap");
  c_ent: cover property (ENTRY_REQ && DEBUG_ENABLE && !DEBUG_ACTIVE);
  c_tag: cover property ($rose(TAG_FUNCTION_ON));
  c_ref: cover property (ACC_VALID && ACC_REFUSED);
endmodule : dsr_bank_properties

bind dsr_debug_status_bank dsr_bank_properties #(.TAG_DELAY(TAG_DELAY)) i_props (.*);

/* sim/dsr_host_model.sv */
// dsr_host_model: host side issuing debug register reads and writes
// assumes: accesses launched at the falling edge, taken at the next rising edge
`timescale 1ns/1ps
module dsr_host_model
  import dsr_pkg::*;
(
  input wire logic  CLOCK,
  input wire logic  [7:0] ACC_RDATA,
  input wire logic  ACC_RVALID,
  input wire logic  ACC_REFUSED,
  output logic      ACC_VALID,
  output logic      ACC_WRITE,
  output dsr_src_t  ACC_SRC,
  output logic [3:0] ACC_INDEX,
  output logic [7:0] ACC_WDATA
);
  // idle bus at time zero
  initial
  begin
    ACC_VALID = 1'b0;
    ACC_WRITE = 1'b0;
    ACC_SRC   = DSR_SRC_NONE;
    ACC_INDEX = 4'h0;
    ACC_WDATA = 8'h00;
  end
  // one access over one rising edge; released lines show inverted data
  task automatic acc(input logic w, input dsr_src_t s, input logic [3:0] i,
                     input logic [7:0] d, output logic [7:0] q, output logic v, output logic f);
    @(negedge CLOCK);
    ACC_VALID = 1'b1;
    ACC_WRITE = w;
    ACC_SRC   = s;
    ACC_INDEX = i;
    ACC_WDATA = d;
    #1 f = ACC_REFUSED;
    @(negedge CLOCK);
    q = ACC_RDATA;
    v = ACC_RVALID;
    ACC_VALID = 1'b0;
    ACC_INDEX = ~i;
    ACC_WDATA = ~d;
  endtask : acc
endmodule : dsr_host_model

/* sim/tb_dsr_debug_status_bank.sv */
// tb_dsr_debug_status_bank: directed register and debug sequence tests
// assumes: host model drives the access port, bench drives context at falling edges
`timescale 1ns/1ps
module tb_dsr_debug_status_bank
  import dsr_pkg::*;
;
  localparam int TD = 4;
  logic CLOCK = 0, RST_N = 0, ENTRY_REQ = 0, EXIT_DONE = 0, TAG_GO_CMD = 0;
  logic DATA_PHASE_DONE = 0, CMD_RECEIVED = 0, TRACE_CMD = 0, SPECIAL_SINGLE_CHIP = 0;
  logic SECURED = 0, ERASE_VERIFY_DONE = 0, ERASED = 0;
  logic [7:0] CPU_CCR = 8'h3C;
  logic [3:0] REGBLOCK_BASE = 4'hA;
  wire logic ACC_VALID, ACC_WRITE, ACC_RVALID, ACC_REFUSED, DEBUG_ENABLE, DEBUG_ACTIVE;
  wire logic FW_TABLE_MAPPED, SERIAL_ENABLE, TAG_FUNCTION_ON, DEBUG_CLOCK_SELECT;
  wire dsr_src_t ACC_SRC;
  wire logic [3:0] ACC_INDEX;
  wire logic [7:0] ACC_WDATA, ACC_RDATA;
  int num_errors = 0, checks = 0, n;
  logic [7:0] q;
  logic v, f;
  dsr_debug_status_bank #(.TAG_DELAY(TD)) i_dut (.*);
  dsr_host_model i_host (.*);
  // free-running clock
  initial
  begin
    forever #12.5 CLOCK = ~CLOCK;
  end
  // comparisons
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic chkb(input string s, input logic e, input logic g);
    chk(s, {7'h00, e}, {7'h00, g});
  endtask : chkb
  // bus and pulse helpers
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    i_host.acc(1'b0, DSR_SRC_HW, i, 8'h00, q, v, f);
    chkb("rvalid", 1'b1, v);
    chk("rdata", e, q);
  endtask : rd
  task automatic wr(input dsr_src_t s, input logic [3:0] i, input logic [7:0] d, input logic e);
    i_host.acc(1'b1, s, i, d, q, v, f);
    chkb("refused", e, f);
  endtask : wr
  task automatic pulse(ref logic s);
    @(negedge CLOCK) s = 1'b1;
    @(negedge CLOCK) s = 1'b0;
  endtask : pulse
  task automatic do_reset();
    @(negedge CLOCK) RST_N = 1'b0;
    repeat (10) @(negedge CLOCK);
    RST_N = 1'b1;
  endtask : do_reset
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  // main sequence
  initial
  begin
    do_reset();
    rd(DSR_IDX_STATUS, 8'h00);
    rd(DSR_IDX_POSITION, 8'h50);
    rd(4'h2, 8'h00);
    wr(DSR_SRC_NONE, DSR_IDX_STATUS, 8'h80, 1'b1);
    pulse(ENTRY_REQ);
    chkb("active", 1'b0, DEBUG_ACTIVE);
    wr(DSR_SRC_HW, DSR_IDX_STATUS, 8'hC1, 1'b0);
    wr(DSR_SRC_HW, DSR_IDX_POSITION, 8'hFF, 1'b0);
    rd(DSR_IDX_STATUS, 8'h80);
    rd(DSR_IDX_POSITION, 8'h50);
    wr(DSR_SRC_FW, DSR_IDX_STATUS, 8'h84, 1'b0);
    wr(DSR_SRC_SECFW, DSR_IDX_STATUS, 8'h80, 1'b0);
    chkb("clock select", 1'b1, DEBUG_CLOCK_SELECT);
    wr(DSR_SRC_HW, DSR_IDX_STATUS, 8'h80, 1'b0);
    rd(DSR_IDX_STATUS, 8'h80);
    $display("registers test done");
    pulse(TAG_GO_CMD);
    rd(DSR_IDX_STATUS, 8'hA0);
    pulse(ENTRY_REQ);
    chkb("mapped", 1'b1, FW_TABLE_MAPPED);
    rd(DSR_IDX_STATUS, 8'hC0);
    rd(DSR_IDX_CCRHOLD, 8'h3C);
    wr(DSR_SRC_FW, DSR_IDX_CCRHOLD, 8'h5A, 1'b0);
    rd(DSR_IDX_CCRHOLD, 8'h5A);
    pulse(DATA_PHASE_DONE);
    rd(DSR_IDX_STATUS, 8'hD0);
    TRACE_CMD = 1'b1;
    pulse(CMD_RECEIVED);
    rd(DSR_IDX_STATUS, 8'hC8);
    wr(DSR_SRC_FW, DSR_IDX_STATUS, 8'h80, 1'b0);
    chkb("active", 1'b0, DEBUG_ACTIVE);
    $display("entry test done");
    @(negedge CLOCK) TAG_GO_CMD = 1'b1;
    @(negedge CLOCK) TAG_GO_CMD = 1'b0;
    n = 0;
    while (TAG_FUNCTION_ON !== 1'b1 && n < 40)
    begin
      @(negedge CLOCK);
      n++;
    end
    if (n == 40)
    begin
      num_errors++;
      finish_test();
    end
    chk("tag delay", 8'(TD), 8'(n));
    chkb("serial", 1'b0, SERIAL_ENABLE);
    wr(DSR_SRC_HW, DSR_IDX_STATUS, 8'h84, 1'b1);
    chkb("clock select", 1'b0, DEBUG_CLOCK_SELECT);
    pulse(ENTRY_REQ);
    chkb("tagging", 1'b0, TAG_FUNCTION_ON);
    chkb("serial", 1'b1, SERIAL_ENABLE);
    pulse(EXIT_DONE);
    chkb("active", 1'b0, DEBUG_ACTIVE);
    $display("tag test done");
    SPECIAL_SINGLE_CHIP = 1'b1;
    do_reset();
    rd(DSR_IDX_STATUS, 8'h80);
    chkb("enable", 1'b1, DEBUG_ENABLE);
    rd(DSR_IDX_CCRHOLD, 8'hD8);
    SECURED = 1'b1;
    do_reset();
    wr(DSR_SRC_HW, DSR_IDX_STATUS, 8'h80, 1'b0);
    rd(DSR_IDX_STATUS, 8'h00);
    ERASE_VERIFY_DONE = 1'b1;
    ERASED = 1'b1;
    wr(DSR_SRC_HW, DSR_IDX_STATUS, 8'h80, 1'b0);
    rd(DSR_IDX_STATUS, 8'h82);
    $display("single-chip test done");
    finish_test();
  end
endmodule : tb_dsr_debug_status_bank

/* src/dsr_debug_status_bank.sv */
// dsr_debug_status_bank: status, condition-code hold and position registers of the debug unit
// assumes: the serial command engine decodes commands and presents one access per cycle,
// marked with its writer class; cpu, mode and erase-test signals are synchronous to CLOCK
//
// Behaviour
// - enable bit gates activation, not hardware commands
// - single-chip firmware sets enable after reset
// - secured: enable only after erase verify completes
// - active flag sets on entry, maps firmware
// - active set by hardware, cleared by firmware
// - tag bit set by tag-go, cleared on entry
// - sixteen cycles later serial off, tagging on
// - no serial commands while tagging active
// - clock select written only by hw/fw commands
// - security-off reads one when secured, erased and verified in single-chip mode
// - position register shadows base bits, read-only
// - ccr hold captures codes, D8 after single-chip reset, else 00
// - registers reached only through debug read/write
`timescale 1ns/1ps
module dsr_debug_status_bank
  import dsr_pkg::*;
#(
  parameter int TAG_DELAY = DSR_TAG_DELAY
)(
  input  wire logic       CLOCK,
  input  wire logic       RST_N,
  // register access from the serial command engine
  input  wire logic       ACC_VALID,
  input  wire logic       ACC_WRITE,
  input  wire dsr_src_t   ACC_SRC,
  input  wire logic [3:0] ACC_INDEX,
  input  wire logic [7:0] ACC_WDATA,
  output logic [7:0]      ACC_RDATA,
  output logic            ACC_RVALID,
  output logic            ACC_REFUSED,
  // debug entry and command status from the engine
  input  wire logic       ENTRY_REQ,
  input  wire logic       EXIT_DONE,
  input  wire logic       TAG_GO_CMD,
  input  wire logic       DATA_PHASE_DONE,
  input  wire logic       CMD_RECEIVED,
  input  wire logic       TRACE_CMD,
  // system context
  input  wire logic       SPECIAL_SINGLE_CHIP,
  input  wire logic       SECURED,
  input  wire logic       ERASE_VERIFY_DONE,
  input  wire logic       ERASED,
  input  wire logic [7:0] CPU_CCR,
  input  wire logic [3:0] REGBLOCK_BASE,
  // outputs to the debug core
  output logic            DEBUG_ENABLE,
  output logic            DEBUG_ACTIVE,
  output logic            FW_TABLE_MAPPED,
  output logic            SERIAL_ENABLE,
  output logic            TAG_FUNCTION_ON,
  output logic            DEBUG_CLOCK_SELECT
);

  // status register fields, then ccr hold, read answer, boot flag and tag sequencer state
  logic           enable_reg;
  logic           active_reg;
  logic           tag_reg;
  logic           sdv_reg;
  logic           trace_reg;
  logic           clksel_reg;
  logic           secoff_reg;
  logic [7:0]     ccr_reg;
  logic [7:0]     rdata_reg;
  logic           rvalid_reg;
  logic           boot_reg;
  dsr_tag_state_t tstate_reg;
  dsr_tag_state_t tstate_next;
  logic           timer_done;

  // access qualification: only debug read and write commands reach the bank
  wire tagging     = (tstate_reg == DSR_TS_TAGGING);
  wire acc_ok      = ACC_VALID && !tagging && (ACC_SRC != DSR_SRC_NONE);
  wire wr          = acc_ok && ACC_WRITE;
  wire rd          = acc_ok && !ACC_WRITE;
  wire wr_status   = wr && (ACC_INDEX == DSR_IDX_STATUS);
  wire wr_ccr      = wr && (ACC_INDEX == DSR_IDX_CCRHOLD);
  wire src_cmd     = (ACC_SRC == DSR_SRC_HW) || (ACC_SRC == DSR_SRC_FW);
  wire enable_lock = SECURED && !ERASE_VERIFY_DONE;
  wire entry_ok    = ENTRY_REQ && enable_reg && !active_reg;

  // firmware sets enable right after a single-chip reset, once verify allows
  wire boot_set = boot_reg && SPECIAL_SINGLE_CHIP && !enable_lock;

  // enable next value: writes blocked while secured and unverified
  wire enable_wr   = wr_status && !enable_lock;
  wire enable_next = boot_set ? 1'b1
                   : (enable_wr ? ACC_WDATA[DSR_BIT_ENABLE] : enable_reg);

  // active: set by hardware on entry, cleared only by firmware store or exit
  wire active_clr  = (wr_status && (ACC_SRC == DSR_SRC_FW)
                     && !ACC_WDATA[DSR_BIT_ACTIVE]) || EXIT_DONE;
  wire active_next = entry_ok ? 1'b1 : (active_clr ? 1'b0 : active_reg);

  // tag: set by tag-go, cleared on entry, which wins
  wire tag_next = entry_ok ? 1'b0
                : ((TAG_GO_CMD && !active_reg) ? 1'b1 : tag_reg);
  wire tag_start = TAG_GO_CMD && !active_reg && !entry_ok;

  // shift-data-valid: set by data phase, cleared by next command or exit
  wire sdv_next = DATA_PHASE_DONE ? 1'b1
                : ((CMD_RECEIVED || EXIT_DONE) ? 1'b0 : sdv_reg);

  // trace flag follows recognised commands
  wire trace_next = CMD_RECEIVED ? TRACE_CMD : trace_reg;

  // clock select: hardware or standard firmware writes only
  wire clksel_next = (wr_status && src_cmd)
                   ? ACC_WDATA[DSR_BIT_CLKSEL] : clksel_reg;

  // security-off: set in single-chip mode if secured, erased and verified; secure firmware writes it there
  wire secoff_set  = SPECIAL_SINGLE_CHIP && SECURED && ERASED
                     && ERASE_VERIFY_DONE;
  wire secoff_next = secoff_set ? 1'b1
                   : ((wr_status && (ACC_SRC == DSR_SRC_SECFW) && SPECIAL_SINGLE_CHIP)
                     ? ACC_WDATA[DSR_BIT_SECOFF] : secoff_reg);

  // ccr hold: capture on activation, else debug write
  wire [7:0] ccr_next = entry_ok ? CPU_CCR : (wr_ccr ? ACC_WDATA : ccr_reg);

  // assembled read views, unimplemented bits zero
  wire [7:0] status_view = {enable_reg, active_reg, tag_reg, sdv_reg,
                            trace_reg, clksel_reg, secoff_reg, 1'b0};
  wire [7:0] pos_base    = 8'(REGBLOCK_BASE);
  wire [7:0] pos_view    = pos_base << DSR_POS_LSB;

  // read mux
  wire [7:0] rd_mux = (ACC_INDEX == DSR_IDX_STATUS)   ? status_view
                    : (ACC_INDEX == DSR_IDX_CCRHOLD)  ? ccr_reg
                    : (ACC_INDEX == DSR_IDX_POSITION) ? pos_view
                    : DSR_ZERO;

  // tag hand-over sequencer
  always_comb
  begin
    tstate_next = tstate_reg;
    case (tstate_reg)
      DSR_TS_IDLE:
        if (tag_start)
          tstate_next = DSR_TS_WAIT;
      DSR_TS_WAIT:
        if (entry_ok)
          tstate_next = DSR_TS_IDLE;
        else if (timer_done)
          tstate_next = DSR_TS_TAGGING;
      DSR_TS_TAGGING:
        if (entry_ok)
          tstate_next = DSR_TS_IDLE;
      default:
        tstate_next = DSR_TS_IDLE;
    endcase
  end

  // delay timer
  dsr_tag_timer #(
    .DELAY (TAG_DELAY)
  ) u_tag_timer (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .start (tag_start),
    .abort (entry_ok),
    .busy  (),
    .done  (timer_done)
  );

  // single-chip boot: ccr preset while enable still clear, flag falls once used
  wire ccr_boot_load = boot_reg && SPECIAL_SINGLE_CHIP && !enable_reg;
  wire boot_next     = boot_reg && !boot_set && SPECIAL_SINGLE_CHIP;

  // next values of the ccr hold and read data registers
  wire [7:0] ccr_load   = ccr_boot_load ? DSR_CCR_SSC_RESET : ccr_next;
  wire [7:0] rdata_next = rd ? rd_mux : rdata_reg;

  // debug enable bit
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      enable_reg <= 1'b0;
    else
      enable_reg <= enable_next;
  end

  // debug active flag
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      active_reg <= 1'b0;
    else
      active_reg <= active_next;
  end

  // tag enable bit
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      tag_reg <= 1'b0;
    else
      tag_reg <= tag_next;
  end

  // shift-data-valid flag
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      sdv_reg <= 1'b0;
    else
      sdv_reg <= sdv_next;
  end

  // trace flag
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      trace_reg <= 1'b0;
    else
      trace_reg <= trace_next;
  end

  // debug clock select bit
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      clksel_reg <= 1'b0;
    else
      clksel_reg <= clksel_next;
  end

  // security-off flag
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      secoff_reg <= 1'b0;
    else
      secoff_reg <= secoff_next;
  end

  // boot flag: armed by reset, spent once enable is set
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      boot_reg <= 1'b1;
    else
      boot_reg <= boot_next;
  end

  // tag hand-over sequencer state
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      tstate_reg <= DSR_TS_IDLE;
    else
      tstate_reg <= tstate_next;
  end

  // ccr hold register
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      ccr_reg <= DSR_CCR_RESET;
    else
      ccr_reg <= ccr_load;
  end

  // read data, held until the next accepted read
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      rdata_reg <= DSR_ZERO;
    else
      rdata_reg <= rdata_next;
  end

  // read answer strobe, one cycle after the read
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      rvalid_reg <= 1'b0;
    else
      rvalid_reg <= rd;
  end

  // register access answers
  assign ACC_RDATA          = rdata_reg;
  assign ACC_RVALID         = rvalid_reg;
  assign ACC_REFUSED        = ACC_VALID && !acc_ok;

  // debug state towards the core
  assign DEBUG_ENABLE       = enable_reg;
  assign DEBUG_ACTIVE       = active_reg;
  assign FW_TABLE_MAPPED    = active_reg;
  assign DEBUG_CLOCK_SELECT = clksel_reg;

  // serial link hands over to tagging
  assign SERIAL_ENABLE      = !tagging;
  assign TAG_FUNCTION_ON    = tagging;

endmodule : dsr_debug_status_bank

/* src/dsr_pkg.sv */
// dsr_pkg: register indices, field positions and timing counts of the debug status bank
// assumes: byte-wide register window addressed by a 4-bit index from the serial command engine
package dsr_pkg;

  // register indices within the debug register window
  localparam logic [3:0] DSR_IDX_STATUS   = 4'h1;
  localparam logic [3:0] DSR_IDX_CCRHOLD  = 4'h6;
  localparam logic [3:0] DSR_IDX_POSITION = 4'h7;

  // status register bit positions
  localparam int DSR_BIT_ENABLE  = 7;
  localparam int DSR_BIT_ACTIVE  = 6;
  localparam int DSR_BIT_TAG     = 5;
  localparam int DSR_BIT_SDV     = 4;
  localparam int DSR_BIT_TRACE   = 3;
  localparam int DSR_BIT_CLKSEL  = 2;
  localparam int DSR_BIT_SECOFF  = 1;

  // position register field
  localparam int DSR_POS_LSB = 3;
  localparam int DSR_POS_MSB = 6;

  // reset values
  localparam logic [7:0] DSR_CCR_SSC_RESET = 8'hD8;
  localparam logic [7:0] DSR_CCR_RESET     = 8'h00;
  localparam logic [7:0] DSR_ZERO          = 8'h00;

  // tag hand-over delay in cycles after the tag enable write
  localparam int DSR_TAG_DELAY = 16;

  // writer classes of a register write
  typedef enum logic [1:0] {
    DSR_SRC_NONE,
    DSR_SRC_HW,
    DSR_SRC_FW,
    DSR_SRC_SECFW
  } dsr_src_t;

  // tag hand-over sequencer
  typedef enum logic [1:0] {
    DSR_TS_IDLE,
    DSR_TS_WAIT,
    DSR_TS_TAGGING
  } dsr_tag_state_t;

endpackage : dsr_pkg

/* src/dsr_tag_timer.sv */
// dsr_tag_timer: counts the delay between the tag enable write and tagging taking over
// assumes: start is a one-cycle pulse; abort cancels a running count
`timescale 1ns/1ps
module dsr_tag_timer
  import dsr_pkg::*;
#(
  parameter int DELAY = DSR_TAG_DELAY
)(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy,
  output logic      done
);

  localparam int CW = $clog2(DELAY + 1);
  localparam logic [CW-1:0] LAST  = CW'(DELAY - 1);
  localparam logic [CW-1:0] CZERO = '0;

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          run_reg;
  logic          run_next;
  wire           at_end = run_reg && (cnt_reg == LAST);

  // next count: restart on start, stop on abort or end
  assign cnt_next = start ? CZERO : (run_reg ? cnt_reg + CW'(1) : cnt_reg);
  assign run_next = start | (run_reg & ~abort & ~at_end);
  assign busy     = run_reg;
  assign done     = at_end & ~abort;

  // counter registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= CZERO;
      run_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
    end
  end

endmodule : dsr_tag_timer
